// ---- shared/adc_seq_pkg.sv ----
// constants, field layout and bus carrier for the converter sequencer
package adc_seq_pkg;

    // byte addresses on the 8-bit cpu path
    localparam logic [3:0] ADDR_RESULT_A_HI = 4'h0;
    localparam logic [3:0] ADDR_RESULT_A_LO = 4'h1;
    localparam logic [3:0] ADDR_RESULT_B_HI = 4'h2;
    localparam logic [3:0] ADDR_RESULT_B_LO = 4'h3;
    localparam logic [3:0] ADDR_RESULT_C_HI = 4'h4;
    localparam logic [3:0] ADDR_RESULT_C_LO = 4'h5;
    localparam logic [3:0] ADDR_RESULT_D_HI = 4'h6;
    localparam logic [3:0] ADDR_RESULT_D_LO = 4'h7;
    localparam logic [3:0] ADDR_CONV_CSR    = 4'h8;

    // conv_control_status fields
    localparam int CSR_FLAG_BIT  = 7;
    localparam int CSR_IE_BIT    = 6;
    localparam int CSR_START_BIT = 5;
    localparam int CSR_SCAN_BIT  = 4;
    localparam int CSR_CHSEL_MSB = 3;

    // result layout: value left-justified, low bits zero
    localparam int  RESULT_BITS = 10;
    localparam int  RESULT_LSB  = 6;
    localparam logic [5:0] RESULT_PAD = 6'h00;
    localparam logic [7:0] BYTE_ZERO  = 8'h00;

    // start source select
    localparam logic [1:0] TRIG_SW    = 2'h0;
    localparam logic [1:0] TRIG_TMR16 = 2'h1;
    localparam logic [1:0] TRIG_TMR8  = 2'h2;
    localparam logic [1:0] TRIG_EXT   = 2'h3;

    // timing
    localparam int CLK_MHZ      = 25;
    localparam int CONV_TIME_NS = 13300;
    localparam int CONV_CYCLES  = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W        = 9;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic       transfer_controller;
        logic [3:0] addr;
        logic [7:0] wdata;
    } cpu_req_t;

endpackage

// ---- rtl/pin_sync3.sv ----
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync3 #(
    parameter logic RESET_VAL = 1'b1
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_n,
    // pin and filtered level
    input  wire logic pin,
    output logic      level
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s1_q    <= RESET_VAL;
            s2_q    <= RESET_VAL;
            s3_q    <= RESET_VAL;
            level_q <= RESET_VAL;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // only accept a level once two late stages agree
            if (s2_q == s3_q) begin
                level_q <= s3_q;
            end
        end
    end

    assign level = level_q;
endmodule // pin_sync3

// ---- rtl/conv_engine.sv ----
// fixed-length conversion timer with result capture
`timescale 1ns/1ps
module conv_engine
    import adc_seq_pkg::*;
#(
    parameter int CYCLES = CONV_CYCLES
) (
    // clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   rst_n,
    // control
    input  wire logic                   start,
    input  wire logic                   abort,
    input  wire logic [3:0]             chan_in,
    // analog side
    input  wire logic [RESULT_BITS-1:0] analog_result,
    output logic [3:0]                  chan_out,
    // status
    output logic                        busy,
    output logic                        done,
    output logic [RESULT_BITS-1:0]      result
);
    typedef enum logic [0:0] {
        ENG_IDLE    = 1'b0,
        ENG_CONVERT = 1'b1
    } eng_state_t;

    localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;
    localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

    eng_state_t             state_q;
    logic [CNT_W-1:0]       cnt_q;
    logic [3:0]             chan_q;
    logic                   done_q;
    logic [RESULT_BITS-1:0] result_q;
    wire                    finish = (state_q == ENG_CONVERT) &&
                                     (cnt_q == CNT_ZERO) && !abort;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q  <= ENG_IDLE;
            cnt_q    <= CNT_ZERO;
            chan_q   <= 4'h0;
            done_q   <= 1'b0;
            result_q <= '0;
        end else begin
            done_q <= finish;
            unique case (state_q)
                ENG_IDLE: begin
                    if (start && !abort) begin
                        state_q <= ENG_CONVERT;
                        cnt_q   <= CNT_LOAD;
                        chan_q  <= chan_in;
                    end
                end
                ENG_CONVERT: begin
                    if (abort) begin
                        state_q <= ENG_IDLE;
                    end else if (finish) begin
                        state_q  <= ENG_IDLE;
                        result_q <= analog_result;
                    end else begin
                        cnt_q <= cnt_q - CNT_ONE;
                    end
                end
            endcase
        end
    end

    assign busy     = (state_q == ENG_CONVERT);
    assign done     = done_q;
    assign result   = result_q;
    assign chan_out = chan_q;

    property p_abort_stops;
        @(posedge clk_sys) disable iff (!rst_n)
        abort |=> !busy && !done;
    endproperty
    a_abort_stops: assert property (p_abort_stops)
        else $error("abort did not stop conversion");

    property p_done_after_count;
        @(posedge clk_sys) disable iff (!rst_n)
        done |-> $past(busy) && !busy;
    endproperty
    a_done_after_count: assert property (p_done_after_count)
        else $error("done without finishing conversion");
endmodule // conv_engine

// ---- rtl/adc_sequencer_result_regs.sv ----
// converter sequencer, control/status and result registers
`timescale 1ns/1ps
//
// Contract
// - four 16-bit result registers, read-only; writes ignored
// - value in bits 15..6, low six bits read zero
// - high byte read directly; low byte latched when high byte read
// - group channels one to four store into results a, b, c, d
// - sixteen inputs in four groups of four consecutive channels
// - single mode converts exactly one channel per start
// - scan mode converts group base to selected channel, repeating
// - start by software bit, timer trigger or external pin
// - one channel takes fixed 13.3 us cycle count
// - end flag bit 7 resets 0, set on single conversion end
// - scan mode sets end flag after whole pass only
// - conversion-end interrupt request to processor
// - module stop halts the converter
// - flag clears on write 0 after read 1, or transfer read
// - interrupt enable bit 6, reset 0, gates the request
// - start bit 5; single self-clears, scan stays until cleared
// - bit 4 selects scan; bits 3..0 select channel
module adc_sequencer_result_regs
    import adc_seq_pkg::*;
#(
    parameter int CYCLES = CONV_CYCLES
) (
    // clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   rst_n,
    // cpu byte bus
    input  wire cpu_req_t               cpu_req,
    output logic [7:0]                  cpu_rdata,
    // start sources
    input  wire logic [1:0]             trig_sel,
    input  wire logic                   timer_trig,
    input  wire logic                   ext_start_trigger_pin_n,
    // power control
    input  wire logic                   module_stop,
    // analog front end
    input  wire logic [RESULT_BITS-1:0] analog_result,
    output logic [3:0]                  analog_chan,
    output logic                        analog_busy,
    // interrupt
    output logic                        conv_end_irq
);
    logic                   flag_q;
    logic                   flag_d;
    logic                   flag_read_q;
    logic                   ie_q;
    logic                   start_q;
    logic                   start_d;
    logic                   scan_q;
    logic [3:0]             chsel_q;
    logic [1:0]             scan_idx_q;
    logic [1:0]             scan_idx_d;
    logic [RESULT_BITS-1:0] result_q [4];
    logic [7:0]             lo_latch_q;
    logic [7:0]             rdata_q;
    logic                   ext_level;
    logic                   ext_prev_q;

    logic                   eng_busy;
    logic                   eng_done;
    logic [3:0]             eng_chan;
    logic [RESULT_BITS-1:0] eng_result;

    // external trigger pin, active low, falling edge starts
    pin_sync3 #(
        .RESET_VAL (1'b1)
    ) u_ext_sync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .pin     (ext_start_trigger_pin_n),
        .level   (ext_level)
    );

    // bus decode
    wire csr_sel  = (cpu_req.addr == ADDR_CONV_CSR);
    wire res_sel  = (cpu_req.addr <= ADDR_RESULT_D_LO);
    wire res_hi   = res_sel && !cpu_req.addr[0];
    wire [1:0] res_idx = cpu_req.addr[2:1];
    wire csr_wr   = cpu_req.wr && csr_sel;
    wire csr_rd   = cpu_req.rd && csr_sel;
    wire res_rd   = cpu_req.rd && res_sel;
    wire hi_rd    = res_rd && res_hi;

    // 16-bit view of each result
    wire [15:0] res_word = {result_q[res_idx], RESULT_PAD};

    wire [7:0] csr_value = {flag_q, ie_q, start_q, scan_q, chsel_q};
    wire [7:0] rd_value  = csr_sel ? csr_value :
                           !res_sel ? BYTE_ZERO :
                           res_hi   ? res_word[15:8] : lo_latch_q;

    // start sources
    wire ext_fall  = ext_prev_q && !ext_level;
    wire tmr_sel   = (trig_sel == TRIG_TMR16) || (trig_sel == TRIG_TMR8);
    wire hw_start  = (tmr_sel && timer_trig) ||
                     ((trig_sel == TRIG_EXT) && ext_fall);

    // channel sequencing; group comes from the upper select bits
    wire [1:0] group_sel = chsel_q[3:2];
    wire [3:0] cur_chan  = scan_q ? {group_sel, scan_idx_q} : chsel_q;
    wire scan_last = (eng_chan[1:0] == chsel_q[1:0]);
    wire pass_end  = eng_done && (!scan_q || scan_last);
    wire eng_abort = module_stop || (!start_q && eng_busy);
    wire eng_start = start_q && !eng_busy && !eng_done && !module_stop;

    conv_engine #(
        .CYCLES (CYCLES)
    ) u_engine (
        .clk_sys       (clk_sys),
        .rst_n         (rst_n),
        .start         (eng_start),
        .abort         (eng_abort),
        .chan_in       (cur_chan),
        .analog_result (analog_result),
        .chan_out      (eng_chan),
        .busy          (eng_busy),
        .done          (eng_done),
        .result        (eng_result)
    );

    // flag clear paths: write 0 after read 1, or transfer read
    wire clr_sw  = csr_wr && !cpu_req.wdata[CSR_FLAG_BIT] && flag_read_q;
    wire clr_dtc = res_rd && cpu_req.transfer_controller;

    // set beats clear in the same cycle
    assign flag_d = pass_end || (flag_q && !(clr_sw || clr_dtc));

    always_comb begin
        start_d = start_q;
        if (csr_wr) begin
            start_d = cpu_req.wdata[CSR_START_BIT];
        end
        if (eng_done && !scan_q) begin
            start_d = 1'b0;
        end
        if (hw_start) begin
            start_d = 1'b1;
        end
        if (module_stop) begin
            start_d = 1'b0;
        end
    end

    always_comb begin
        scan_idx_d = scan_idx_q;
        if (!start_q) begin
            scan_idx_d = 2'h0;
        end else if (eng_done && scan_q) begin
            scan_idx_d = scan_last ? 2'h0 : eng_chan[1:0] + 2'h1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flag_q      <= 1'b0;
            flag_read_q <= 1'b0;
            ie_q        <= 1'b0;
            start_q     <= 1'b0;
            scan_q      <= 1'b0;
            chsel_q     <= 4'h0;
            scan_idx_q  <= 2'h0;
            ext_prev_q  <= 1'b1;
        end else begin
            flag_q      <= flag_d;
            flag_read_q <= flag_d && (flag_read_q || (csr_rd && flag_q)) &&
                           !csr_wr;
            start_q     <= start_d;
            scan_idx_q  <= scan_idx_d;
            ext_prev_q  <= ext_level;
            if (csr_wr) begin
                ie_q    <= cpu_req.wdata[CSR_IE_BIT];
                scan_q  <= cpu_req.wdata[CSR_SCAN_BIT];
                chsel_q <= cpu_req.wdata[CSR_CHSEL_MSB:0];
            end
        end
    end

    // results: only the engine writes them, bus writes fall away
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 4; i++) begin
                result_q[i] <= '0;
            end
        end else if (eng_done) begin
            result_q[eng_chan[1:0]] <= eng_result;
        end
    end

    // low byte frozen at the high read so a word never tears
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lo_latch_q <= BYTE_ZERO;
            rdata_q    <= BYTE_ZERO;
        end else begin
            if (hi_rd) begin
                lo_latch_q <= res_word[7:0];
            end
            if (cpu_req.rd) begin
                rdata_q <= rd_value;
            end
        end
    end

    assign cpu_rdata    = rdata_q;
    assign analog_chan  = eng_chan;
    assign analog_busy  = eng_busy;
    assign conv_end_irq = flag_q && ie_q;

    property p_result_ro;
        @(posedge clk_sys) disable iff (!rst_n)
        (cpu_req.wr && res_sel && !eng_done) |=> $stable(result_q[0]) &&
            $stable(result_q[1]) && $stable(result_q[2]) &&
            $stable(result_q[3]);
    endproperty
    a_result_ro: assert property (p_result_ro)
        else $error("bus write changed a result register");

    property p_low_zero;
        @(posedge clk_sys) disable iff (!rst_n)
        (res_rd && !res_hi) |=> rdata_q[RESULT_LSB-1:0] == RESULT_PAD;
    endproperty
    a_low_zero: assert property (p_low_zero)
        else $error("low result bits not zero");

    property p_hi_then_lo;
        @(posedge clk_sys) disable iff (!rst_n)
        hi_rd |=> rdata_q == $past(res_word[15:8]) &&
            lo_latch_q == $past(res_word[7:0]);
    endproperty
    a_hi_then_lo: assert property (p_hi_then_lo)
        else $error("word read bytes from different values");

    property p_store_slot;
        @(posedge clk_sys) disable iff (!rst_n)
        eng_done |=> result_q[$past(eng_chan[1:0])] == $past(eng_result);
    endproperty
    a_store_slot: assert property (p_store_slot)
        else $error("result stored in wrong register");

    property p_single_clear;
        @(posedge clk_sys) disable iff (!rst_n)
        (eng_done && !scan_q && !hw_start) |=> !start_q && flag_q;
    endproperty
    a_single_clear: assert property (p_single_clear)
        else $error("single mode did not end cleanly");

    property p_scan_mid;
        @(posedge clk_sys) disable iff (!rst_n)
        (eng_done && scan_q && !scan_last && !flag_q) |=> !flag_q;
    endproperty
    a_scan_mid: assert property (p_scan_mid)
        else $error("end flag set mid scan");

    property p_scan_wrap;
        @(posedge clk_sys) disable iff (!rst_n)
        (eng_done && scan_q && scan_last && start_q && !module_stop &&
         !csr_wr) |=> scan_idx_q == 2'h0 && start_q ##[1:2] eng_busy;
    endproperty
    a_scan_wrap: assert property (p_scan_wrap)
        else $error("scan did not restart at group base");

    property p_stop_halts;
        @(posedge clk_sys) disable iff (!rst_n)
        module_stop |=> !start_q ##1 !eng_busy;
    endproperty
    a_stop_halts: assert property (p_stop_halts)
        else $error("module stop did not halt");

    property p_irq_gate;
        @(posedge clk_sys) disable iff (!rst_n)
        (pass_end && ie_q && !csr_wr) |=> conv_end_irq;
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("interrupt not raised at conversion end");

    property p_ext_start;
        @(posedge clk_sys) disable iff (!rst_n)
        (trig_sel == TRIG_EXT && ext_fall && !module_stop) |=> start_q;
    endproperty
    a_ext_start: assert property (p_ext_start)
        else $error("external trigger ignored");

    property p_set_wins;
        @(posedge clk_sys) disable iff (!rst_n)
        pass_end |=> flag_q;
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("flag set lost to clear");

    property p_irq_drop;
        @(posedge clk_sys) disable iff (!rst_n)
        ((clr_sw || clr_dtc) && !pass_end) |=> !conv_end_irq;
    endproperty
    a_irq_drop: assert property (p_irq_drop)
        else $error("interrupt held after flag clear");

    property p_timer_start;
        @(posedge clk_sys) disable iff (!rst_n)
        (tmr_sel && timer_trig && !module_stop) |=> start_q;
    endproperty
    a_timer_start: assert property (p_timer_start)
        else $error("timer trigger ignored");
endmodule // adc_sequencer_result_regs

// ---- dv/analog_front_model.sv ----
// analog front-end stand-in: level tied to the selected channel
`timescale 1ns/1ps
module analog_front_model
    import adc_seq_pkg::*;
(
    // converter side
    input  wire logic [3:0]             analog_chan,
    input  wire logic                   analog_busy,
    // bench side
    input  wire logic [5:0]             salt,
    // sampled level
    output logic [RESULT_BITS-1:0]      analog_result
);
    wire logic [RESULT_BITS-1:0] level;
    assign level = {analog_chan, salt};
    // not held outside a conversion, so show the inverse there
    assign analog_result = analog_busy ? level : ~level;
endmodule // analog_front_model

// ---- dv/testbench.sv ----
// self-checking bench for the converter sequencer and result registers
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
    err_count++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
    end end
module testbench;
    import adc_seq_pkg::*;
    localparam int CYC = 8;
    logic                   clk_sys     = 1'b0;
    logic                   rst_n       = 1'b0;
    cpu_req_t               cpu_req     = '0;
    logic [1:0]             trig_sel    = TRIG_SW;
    logic                   timer_trig  = 1'b0;
    logic                   ext_pin_n   = 1'b1;
    logic                   module_stop = 1'b0;
    logic [5:0]             salt        = 6'h00;
    logic [7:0]             cpu_rdata;
    logic [RESULT_BITS-1:0] analog_result;
    logic [3:0]             analog_chan;
    logic                   analog_busy;
    logic                   conv_end_irq;
    logic [7:0]             d;
    logic [3:0]             ch;
    logic                   ie;
    int                     err_count       = 0;
    int                     samples_checked = 0;
    int                     seed            = 97;
    int                     run_len         = 0;
    int                     busy_len        = 0;

    adc_sequencer_result_regs #(.CYCLES(CYC)) adc_sequencer_result_regs_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .cpu_req(cpu_req),
        .cpu_rdata(cpu_rdata), .trig_sel(trig_sel), .timer_trig(timer_trig),
        .ext_start_trigger_pin_n(ext_pin_n), .module_stop(module_stop),
        .analog_result(analog_result), .analog_chan(analog_chan),
        .analog_busy(analog_busy), .conv_end_irq(conv_end_irq));

    analog_front_model analog_front_model_inst (
        .analog_chan(analog_chan), .analog_busy(analog_busy),
        .salt(salt), .analog_result(analog_result));

    always #20 clk_sys = ~clk_sys;

    // length of the last busy stretch, in clock cycles
    always @(posedge clk_sys) begin
        if (analog_busy === 1'b1) begin
            run_len <= run_len + 1;
        end else if (run_len != 0) begin
            busy_len <= run_len;
            run_len  <= 0;
        end
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // one byte access, held from falling edge through the taking edge
    task automatic bus(input logic r, input logic dt, input logic [3:0] a,
                       input logic [7:0] w);
        @(negedge clk_sys);
        cpu_req = '{rd: r, wr: !r, transfer_controller: dt, addr: a, wdata: w};
        @(negedge clk_sys);
        cpu_req = '0;
        d = cpu_rdata;
    endtask

    task automatic wait_flag();
        int n;
        n = 0;
        d = 8'h00;
        while (d[CSR_FLAG_BIT] !== 1'b1) begin
            n = n + 1;
            if (n > 200) begin
                err_count++;
                $display("CHECK FAILED end flag exp 1 got 0");
                close_out();
            end
            bus(1'b1, 1'b0, ADDR_CONV_CSR, 8'h00);
        end
    endtask

    // high byte first, then low byte from the latch
    task automatic check_res(input int idx, input logic [9:0] v);
        bus(1'b1, 1'b0, 4'(2 * idx), 8'h00);
        `CHK("result hi", v[9:2], d)
        bus(1'b1, 1'b0, 4'(2 * idx + 1), 8'h00);
        `CHK("result lo", {v[1:0], 6'h00}, d)
    endtask

    task automatic clear_flag();
        bus(1'b1, 1'b0, ADDR_CONV_CSR, 8'h00);
        bus(1'b0, 1'b0, ADDR_CONV_CSR, d & 8'h7f);
        bus(1'b1, 1'b0, ADDR_CONV_CSR, 8'h00);
        `CHK("flag clear", 1'b0, d[CSR_FLAG_BIT])
    endtask

    task automatic test_end(input string nm);
        $display("test %s done, mismatches %0d", nm, err_count);
    endtask

    initial begin
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        rst_n = 1'b1;
        bus(1'b1, 1'b0, ADDR_CONV_CSR, 8'h00);
        `CHK("csr reset", 8'h00, d)
        bus(1'b0, 1'b0, ADDR_RESULT_A_HI, 8'hff);
        check_res(0, 10'h000);
        bus(1'b1, 1'b0, 4'h9, 8'h00);
        `CHK("unmapped", 8'h00, d)
        test_end("reset");
        for (int i = 0; i < 16; i++) begin
            ch = 4'(i);
            ie = 1'(i % 2);
            salt = 6'($random(seed));
            bus(1'b0, 1'b0, ADDR_CONV_CSR, {1'b0, ie, 1'b1, 1'b0, ch});
            wait_flag();
            `CHK("start self clear", 1'b0, d[CSR_START_BIT])
            `CHK("irq", ie, conv_end_irq)
            check_res(i % 4, {ch, salt});
            `CHK("one channel", 1'b0, analog_busy)
            `CHK("chan held", ch, analog_chan)
            `CHK("conv length", CYC, busy_len)
            clear_flag();
            `CHK("irq off", 1'b0, conv_end_irq)
        end
        test_end("single");
        // channels 12..15 last filled a..d, so group 2 must overwrite all
        salt = 6'($random(seed));
        bus(1'b0, 1'b0, ADDR_CONV_CSR, 8'h3b);
        wait_flag();
        `CHK("scan start held", 1'b1, d[CSR_START_BIT])
        for (int k = 0; k < 4; k++) begin
            check_res(k, {4'(8 + k), salt});
        end
        bus(1'b1, 1'b0, ADDR_CONV_CSR, 8'h00);
        bus(1'b0, 1'b0, ADDR_CONV_CSR, d & 8'h7f);
        wait_flag();
        bus(1'b0, 1'b0, ADDR_CONV_CSR, 8'h1b);
        repeat (3) @(negedge clk_sys);
        `CHK("scan stop", 1'b0, analog_busy)
        test_end("scan");
        bus(1'b0, 1'b0, ADDR_CONV_CSR, 8'h20);
        wait_flag();
        bus(1'b0, 1'b0, ADDR_CONV_CSR, 8'h80);
        bus(1'b0, 1'b0, ADDR_CONV_CSR, 8'h00);
        bus(1'b1, 1'b0, ADDR_CONV_CSR, 8'h00);
        `CHK("clear unarmed", 1'b1, d[CSR_FLAG_BIT])
        bus(1'b1, 1'b1, ADDR_RESULT_A_HI, 8'h00);
        bus(1'b1, 1'b0, ADDR_CONV_CSR, 8'h00);
        `CHK("transfer clear", 1'b0, d[CSR_FLAG_BIT])
        test_end("flag");
        for (int t = 1; t < 4; t++) begin
            trig_sel = 2'(t);
            salt = 6'($random(seed));
            bus(1'b0, 1'b0, ADDR_CONV_CSR, 8'h05);
            if (t == 3) begin
                ext_pin_n = 1'b0;
            end else begin
                timer_trig = 1'b1;
            end
            @(negedge clk_sys);
            timer_trig = 1'b0;
            wait_flag();
            ext_pin_n = 1'b1;
            check_res(1, {4'h5, salt});
            clear_flag();
        end
        trig_sel = TRIG_SW;
        test_end("triggers");
        bus(1'b0, 1'b0, ADDR_CONV_CSR, 8'h33);
        repeat (5) @(negedge clk_sys);
        module_stop = 1'b1;
        repeat (3) @(negedge clk_sys);
        `CHK("stop busy", 1'b0, analog_busy)
        bus(1'b1, 1'b0, ADDR_CONV_CSR, 8'h00);
        `CHK("stop start", 1'b0, d[CSR_START_BIT])
        module_stop = 1'b0;
        test_end("module stop");
        close_out();
    end
endmodule // testbench
